// ---- src/apc_pkg.sv ----
// Constants, types and helpers for the audio port routing and clocking block
//
// Contract
// - Pulse-frame data starts offset bit clocks late
// - Input-to-output loopback drives data pin from input
// - Record-to-playback loopback feeds record samples to playback
// - Clock inversion bit inverts the selected inward bit clock, not the pin outputs
// - Keep-alive keeps clocks running while codec down
// - Two-bit selector picks divider source clock
// - Divider power bit stops or runs divider
// - Seven-bit ratio, zero means divide by 128
// - Secondary bit clock source: pin, data pin, none
// - Secondary frame clock source uses same encoding
// - Secondary data input from general pin or none
// - Record frame clock only from general pin
// - Select primary or secondary bit clock inward
// - Select primary or secondary frame clock inward
// - Split bit picks record frame clock source
// - Select primary or secondary data input inward
// - Primary bit clock output: generated or secondary
// - Secondary bit clock output: primary or generated
// - Primary frame clock output: playback, record, secondary
// - Secondary frame clock output: primary, playback, record
// - Primary data output: interface data or secondary input
// - Secondary data output: primary input or interface data
// - Bit and frame clock directions set independently
// - Word format: standard, pulse-frame, right, left
// - Word length 16, 20, 24 or 32 bits
package apc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_CTRL_ONE = 8'h1B;
  localparam logic [7:0] OFF_SLOT = 8'h1C;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h1D;
  localparam logic [7:0] OFF_DIV = 8'h1E;
  localparam logic [7:0] OFF_SEC_SRC = 8'h1F;
  localparam logic [7:0] OFF_IN_SEL = 8'h20;
  localparam logic [7:0] OFF_OUT_ROUTE = 8'h21;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  // Reset values and writable-bit masks
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h01;
  localparam logic [7:0] MASK_CTRL_ONE = 8'hFC;
  localparam logic [7:0] MASK_CTRL_TWO = 8'h3F;
  localparam logic [7:0] MASK_IN_SEL = 8'hEF;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FMT_LSB = 6;
  localparam int WL_LSB = 4;
  localparam int BCLK_DIR_BIT = 3;
  localparam int WCLK_DIR_BIT = 2;
  localparam int LOOP_PIN_BIT = 5;
  localparam int LOOP_PATH_BIT = 4;
  localparam int INV_BIT = 3;
  localparam int KEEP_BIT = 2;
  localparam int DIV_SRC_LSB = 0;
  localparam int DIV_PWR_BIT = 7;
  localparam int SEC_BCLK_LSB = 5;
  localparam int SEC_WCLK_LSB = 2;
  localparam int SEC_DIN_LSB = 0;
  localparam int REC_WCLK_LSB = 5;
  localparam int SEL_BCLK_BIT = 3;
  localparam int SEL_WCLK_BIT = 2;
  localparam int SPLIT_BIT = 1;
  localparam int SEL_DIN_BIT = 0;
  localparam int PBCLK_SEL_BIT = 7;
  localparam int SBCLK_SEL_BIT = 6;
  localparam int PWCLK_LSB = 4;
  localparam int SWCLK_LSB = 2;
  localparam int PDOUT_SEL_BIT = 1;
  localparam int SDOUT_SEL_BIT = 0;

  // Pin synchroniser lanes
  localparam int PIN_PB = 0;
  localparam int PIN_PW = 1;
  localparam int PIN_PD = 2;
  localparam int PIN_DP = 3;
  localparam int PIN_GP = 4;
  localparam int PIN_COUNT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [1:0] FMT_STANDARD = 2'h0;
  localparam logic [1:0] FMT_PULSE = 2'h1;
  localparam logic [1:0] FMT_RIGHT = 2'h2;
  localparam logic [1:0] FMT_LEFT = 2'h3;
  localparam logic [2:0] SRC_GP = 3'h0;
  localparam logic [2:0] SRC_DPIN = 3'h3;
  localparam logic [1:0] DIN_GP = 2'h0;
  localparam logic [1:0] DIV_PB_PROC = 2'h0;
  localparam logic [1:0] DIV_PB_MOD = 2'h1;
  localparam logic [1:0] DIV_REC_PROC = 2'h2;
  localparam logic [1:0] DIV_REC_MOD = 2'h3;
  localparam logic [1:0] PW_PB = 2'h0;
  localparam logic [1:0] PW_REC = 2'h1;
  localparam logic [1:0] PW_SEC = 2'h2;
  localparam logic [1:0] SW_PRIM = 2'h0;
  localparam logic [1:0] SW_PB = 2'h1;
  localparam logic [1:0] SW_REC = 2'h2;
  localparam logic [8:0] STANDARD_DELAY = 9'h001;
  localparam logic [7:0] DIV_FULL = 8'h80;
  localparam logic [5:0] WORD_FULL = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } apc_reg_req_t;

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] slot;
    logic [7:0] ctrl_two;
    logic [7:0] div;
    logic [7:0] sec_src;
    logic [7:0] in_sel;
    logic [7:0] out_route;
  } apc_regs_t;

  typedef struct packed {
    logic [1:0] fmt;
    logic [1:0] wl;
    logic [7:0] offset;
  } apc_frm_cfg_t;

  typedef struct packed {
    logic wclk_prev;
    logic pend;
    logic [8:0] wait_cnt;
    logic [5:0] bits_left;
    logic [8:0] hi_cnt;
    logic [8:0] hi_len;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [31:0] word;
    logic word_valid;
  } apc_frm_state_t;

  typedef struct packed {
    apc_regs_t regs;
    logic [7:0] rdata;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic bclk_prev;
    logic [6:0] div_cnt;
    logic gen_bclk;
    logic pbclk;
    logic pbclk_oe;
    logic pwclk;
    logic pwclk_oe;
    logic pdout;
    logic pdout_oe;
    logic sbclk;
    logic swclk;
    logic sdout;
    logic [31:0] pb_sample;
    logic pb_valid;
  } apc_top_state_t;

  // Word length code to bit count
  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    case (code)
      2'h0: wl_bits = 6'h10;
      2'h1: wl_bits = 6'h14;
      2'h2: wl_bits = 6'h18;
      default: wl_bits = 6'h20;
    endcase
  endfunction : wl_bits

endpackage : apc_pkg

// ---- src/apc_port.sv ----
// Audio serial port routing, bit clock divider and word framing
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Word framer for one direction
module apc_framer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Configuration
  input wire apc_pkg::apc_frm_cfg_t cfg_in,
  // Serial timing
  input wire logic bclk_rise_in,
  input wire logic wclk_in,
  input wire logic data_in,
  // Words
  input wire logic [31:0] tx_word_in,
  output logic [31:0] word_out,
  output logic word_valid_out,
  output logic tx_bit_out
);

  apc_pkg::apc_frm_state_t s;
  apc_pkg::apc_frm_state_t next_s;
  logic [5:0] wl;
  logic edge_hit;
  logic [8:0] delay;
  logic [8:0] wt;
  logic [31:0] rx_new;

  always_comb
  begin
    next_s = s;
    next_s.word_valid = 1'b0;
    wl = apc_pkg::wl_bits(cfg_in.wl);
    edge_hit = 1'b0;
    delay = 9'h000;
    wt = s.wait_cnt;
    rx_new = s.rx;
    if (bclk_rise_in)
    begin
      next_s.wclk_prev = wclk_in;
      if (s.wclk_prev && !wclk_in)
      begin
        next_s.hi_len = s.hi_cnt;
        next_s.hi_cnt = 9'h000;
      end
      else if (wclk_in && s.hi_cnt != 9'h1FF)
      begin
        next_s.hi_cnt = s.hi_cnt + 9'h001;
      end
      // Frame start edge and first-bit delay per format
      if (cfg_in.fmt == apc_pkg::FMT_STANDARD)
      begin
        edge_hit = s.wclk_prev && !wclk_in;
      end
      else
      begin
        edge_hit = !s.wclk_prev && wclk_in;
      end
      case (cfg_in.fmt)
        apc_pkg::FMT_STANDARD: delay = apc_pkg::STANDARD_DELAY;
        apc_pkg::FMT_PULSE: delay = {1'b0, cfg_in.offset};
        apc_pkg::FMT_RIGHT:
        begin
          if (s.hi_len > {3'h0, wl})
          begin
            delay = s.hi_len - {3'h0, wl};
          end
        end
        default: delay = 9'h000;
      endcase
      if (edge_hit)
      begin
        next_s.tx = tx_word_in;
        next_s.bits_left = 6'h00;
        next_s.pend = 1'b1;
        wt = delay;
      end
      if (next_s.pend)
      begin
        if (wt == 9'h000)
        begin
          next_s.pend = 1'b0;
          next_s.bits_left = wl;
        end
        else
        begin
          next_s.wait_cnt = wt - 9'h001;
        end
      end
      if (next_s.bits_left != 6'h00)
      begin
        rx_new = {s.rx[30:0], data_in};
        next_s.rx = rx_new;
        next_s.tx = {next_s.tx[30:0], 1'b0};
        next_s.bits_left = next_s.bits_left - 6'h01;
        if (next_s.bits_left == 6'h00)
        begin
          next_s.word = rx_new << (apc_pkg::WORD_FULL - wl);
          next_s.word_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign word_out = s.word;
  assign word_valid_out = s.word_valid;
  assign tx_bit_out = s.tx[31];

endmodule : apc_framer

////////////////////////////////////////////////////////////////////////////////
// Top: registers, divider, pin muxing and two framers
module apc_port (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Register port
  input wire apc_pkg::apc_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Pins, sampled asynchronously
  input wire logic primary_bit_clock_in,
  input wire logic primary_frame_clock_in,
  input wire logic primary_data_in,
  input wire logic data_pin_in,
  input wire logic general_purpose_pin_in,
  // Pin drivers
  output logic primary_bit_clock_out,
  output logic primary_bit_clock_oe_out,
  output logic primary_frame_clock_out,
  output logic primary_frame_clock_oe_out,
  output logic primary_data_out,
  output logic primary_data_oe_out,
  output logic secondary_bit_clock_out,
  output logic secondary_frame_clock_out,
  output logic secondary_data_out,
  // Clock generator
  input wire logic playback_processing_clock_en_in,
  input wire logic playback_modulator_clock_en_in,
  input wire logic record_processing_clock_en_in,
  input wire logic record_modulator_clock_en_in,
  input wire logic playback_sample_rate_clock_in,
  input wire logic record_sample_rate_clock_in,
  input wire logic codec_powered_down_in,
  // Sample paths
  input wire logic [31:0] record_sample_in,
  output logic [31:0] playback_sample_out,
  output logic playback_valid_out
);

  apc_pkg::apc_top_state_t s;
  apc_pkg::apc_top_state_t next_s;
  apc_pkg::apc_regs_t r;
  apc_pkg::apc_frm_cfg_t cfg;
  logic run;
  logic src_pulse;
  logic [7:0] ratio;
  logic [6:0] cnt_new;
  logic gp;
  logic dpin;
  logic sec_bclk;
  logic sec_wclk;
  logic sec_din;
  logic rec_wclk_ext;
  logic prim_bclk_lvl;
  logic prim_wclk_lvl;
  logic iface_bclk;
  logic pb_wclk;
  logic rec_wclk;
  logic din_sel;
  logic bclk_rise;
  logic iface_dout;
  logic pb_fs;
  logic rec_fs;
  logic [31:0] pb_word;
  logic pb_word_valid;
  logic rec_tx_bit;

  assign r = s.regs;
  assign cfg = '{fmt: r.ctrl_one[apc_pkg::FMT_LSB +: 2],
                 wl: r.ctrl_one[apc_pkg::WL_LSB +: 2],
                 offset: r.slot};

  //////////////////////////////////////////////////////////////////////////////
  // Framers
  apc_framer u_playback_framer (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .cfg_in(cfg),
    .bclk_rise_in(bclk_rise),
    .wclk_in(pb_wclk),
    .data_in(din_sel),
    .tx_word_in(32'h0000_0000),
    .word_out(pb_word),
    .word_valid_out(pb_word_valid),
    .tx_bit_out()
  );

  apc_framer u_record_framer (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .cfg_in(cfg),
    .bclk_rise_in(bclk_rise),
    .wclk_in(rec_wclk),
    .data_in(1'b0),
    .tx_word_in(record_sample_in),
    .word_out(),
    .word_valid_out(),
    .tx_bit_out(rec_tx_bit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Routing
  always_comb
  begin
    run = !codec_powered_down_in || r.ctrl_two[apc_pkg::KEEP_BIT];
    pb_fs = playback_sample_rate_clock_in && run;
    rec_fs = record_sample_rate_clock_in && run;
    gp = s.sync2[apc_pkg::PIN_GP];
    dpin = s.sync2[apc_pkg::PIN_DP];
    case (r.sec_src[apc_pkg::SEC_BCLK_LSB +: 3])
      apc_pkg::SRC_GP: sec_bclk = gp;
      apc_pkg::SRC_DPIN: sec_bclk = dpin;
      default: sec_bclk = 1'b0;
    endcase
    case (r.sec_src[apc_pkg::SEC_WCLK_LSB +: 3])
      apc_pkg::SRC_GP: sec_wclk = gp;
      apc_pkg::SRC_DPIN: sec_wclk = dpin;
      default: sec_wclk = 1'b0;
    endcase
    sec_din = (r.sec_src[apc_pkg::SEC_DIN_LSB +: 2] == apc_pkg::DIN_GP) && gp;
    rec_wclk_ext = (r.in_sel[apc_pkg::REC_WCLK_LSB +: 3] == apc_pkg::SRC_GP) && gp;
    // Own driven level when a clock pin is an output
    prim_bclk_lvl = r.ctrl_one[apc_pkg::BCLK_DIR_BIT] ? s.pbclk
                                                     : s.sync2[apc_pkg::PIN_PB];
    prim_wclk_lvl = r.ctrl_one[apc_pkg::WCLK_DIR_BIT] ? s.pwclk
                                                     : s.sync2[apc_pkg::PIN_PW];
    iface_bclk = (r.in_sel[apc_pkg::SEL_BCLK_BIT] ? sec_bclk : prim_bclk_lvl)
                 ^ r.ctrl_two[apc_pkg::INV_BIT];
    pb_wclk = r.in_sel[apc_pkg::SEL_WCLK_BIT] ? sec_wclk : prim_wclk_lvl;
    rec_wclk = r.in_sel[apc_pkg::SPLIT_BIT] ? rec_wclk_ext : pb_wclk;
    din_sel = r.in_sel[apc_pkg::SEL_DIN_BIT] ? sec_din : s.sync2[apc_pkg::PIN_PD];
    bclk_rise = iface_bclk && !s.bclk_prev;
    iface_dout = r.ctrl_two[apc_pkg::LOOP_PIN_BIT] ? din_sel : rec_tx_bit;
    case (r.ctrl_two[apc_pkg::DIV_SRC_LSB +: 2])
      apc_pkg::DIV_PB_PROC: src_pulse = playback_processing_clock_en_in;
      apc_pkg::DIV_PB_MOD: src_pulse = playback_modulator_clock_en_in;
      apc_pkg::DIV_REC_PROC: src_pulse = record_processing_clock_en_in;
      apc_pkg::DIV_REC_MOD: src_pulse = record_modulator_clock_en_in;
      default: src_pulse = 1'b0;
    endcase
    ratio = (r.div[6:0] == 7'h00) ? apc_pkg::DIV_FULL : {1'b0, r.div[6:0]};
    cnt_new = ({1'b0, s.div_cnt} == ratio - 8'h01) ? 7'h00 : s.div_cnt + 7'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.sync1 = {general_purpose_pin_in, data_pin_in, primary_data_in,
                    primary_frame_clock_in, primary_bit_clock_in};
    next_s.sync2 = s.sync1;
    next_s.bclk_prev = iface_bclk;
    // Bit clock divider
    if (!r.div[apc_pkg::DIV_PWR_BIT] || !run)
    begin
      next_s.div_cnt = 7'h00;
      next_s.gen_bclk = 1'b0;
    end
    else if (ratio == 8'h01)
    begin
      next_s.gen_bclk = src_pulse;
    end
    else if (src_pulse)
    begin
      next_s.div_cnt = cnt_new;
      next_s.gen_bclk = {1'b0, cnt_new} < (ratio >> 1);
    end
    // Pin drivers
    next_s.pbclk = r.out_route[apc_pkg::PBCLK_SEL_BIT] ? sec_bclk : s.gen_bclk;
    next_s.pbclk_oe = r.ctrl_one[apc_pkg::BCLK_DIR_BIT];
    case (r.out_route[apc_pkg::PWCLK_LSB +: 2])
      apc_pkg::PW_PB: next_s.pwclk = pb_fs;
      apc_pkg::PW_REC: next_s.pwclk = rec_fs;
      apc_pkg::PW_SEC: next_s.pwclk = sec_wclk;
      default: next_s.pwclk = 1'b0;
    endcase
    next_s.pwclk_oe = r.ctrl_one[apc_pkg::WCLK_DIR_BIT];
    next_s.pdout = r.out_route[apc_pkg::PDOUT_SEL_BIT] ? sec_din : iface_dout;
    next_s.pdout_oe = (r.sec_src[apc_pkg::SEC_BCLK_LSB +: 3] != apc_pkg::SRC_DPIN)
                      && (r.sec_src[apc_pkg::SEC_WCLK_LSB +: 3] != apc_pkg::SRC_DPIN);
    next_s.sbclk = r.out_route[apc_pkg::SBCLK_SEL_BIT] ? s.gen_bclk : prim_bclk_lvl;
    case (r.out_route[apc_pkg::SWCLK_LSB +: 2])
      apc_pkg::SW_PRIM: next_s.swclk = prim_wclk_lvl;
      apc_pkg::SW_PB: next_s.swclk = pb_fs;
      apc_pkg::SW_REC: next_s.swclk = rec_fs;
      default: next_s.swclk = 1'b0;
    endcase
    next_s.sdout = r.out_route[apc_pkg::SDOUT_SEL_BIT] ? iface_dout
                                                       : s.sync2[apc_pkg::PIN_PD];
    // Playback samples
    next_s.pb_valid = pb_word_valid;
    if (pb_word_valid)
    begin
      next_s.pb_sample = r.ctrl_two[apc_pkg::LOOP_PATH_BIT] ? record_sample_in
                                                            : pb_word;
    end
    // Register writes
    if (reg_req_in.write)
    begin
      case (reg_req_in.addr)
        apc_pkg::OFF_CTRL_ONE: next_s.regs.ctrl_one = reg_req_in.wdata & apc_pkg::MASK_CTRL_ONE;
        apc_pkg::OFF_SLOT: next_s.regs.slot = reg_req_in.wdata;
        apc_pkg::OFF_CTRL_TWO: next_s.regs.ctrl_two = reg_req_in.wdata & apc_pkg::MASK_CTRL_TWO;
        apc_pkg::OFF_DIV: next_s.regs.div = reg_req_in.wdata;
        apc_pkg::OFF_SEC_SRC: next_s.regs.sec_src = reg_req_in.wdata;
        apc_pkg::OFF_IN_SEL: next_s.regs.in_sel = reg_req_in.wdata & apc_pkg::MASK_IN_SEL;
        apc_pkg::OFF_OUT_ROUTE: next_s.regs.out_route = reg_req_in.wdata;
        default: next_s.regs = s.regs;
      endcase
    end
    // Register reads, data one cycle later
    next_s.rdata = 8'h00;
    if (reg_req_in.read)
    begin
      case (reg_req_in.addr)
        apc_pkg::OFF_CTRL_ONE: next_s.rdata = r.ctrl_one;
        apc_pkg::OFF_SLOT: next_s.rdata = r.slot;
        apc_pkg::OFF_CTRL_TWO: next_s.rdata = r.ctrl_two;
        apc_pkg::OFF_DIV: next_s.rdata = r.div;
        apc_pkg::OFF_SEC_SRC: next_s.rdata = r.sec_src;
        apc_pkg::OFF_IN_SEL: next_s.rdata = r.in_sel;
        apc_pkg::OFF_OUT_ROUTE: next_s.rdata = r.out_route;
        apc_pkg::OFF_STATUS: next_s.rdata = {4'h0, pb_wclk, iface_bclk, run, s.gen_bclk};
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s <= '0;
      s.regs.div <= apc_pkg::RST_DIV;
      s.pdout_oe <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign primary_bit_clock_out = s.pbclk;
  assign primary_bit_clock_oe_out = s.pbclk_oe;
  assign primary_frame_clock_out = s.pwclk;
  assign primary_frame_clock_oe_out = s.pwclk_oe;
  assign primary_data_out = s.pdout;
  assign primary_data_oe_out = s.pdout_oe;
  assign secondary_bit_clock_out = s.sbclk;
  assign secondary_frame_clock_out = s.swclk;
  assign secondary_data_out = s.sdout;
  assign playback_sample_out = s.pb_sample;
  assign playback_valid_out = s.pb_valid;

endmodule : apc_port

// ---- tb/apc_port_props.sv ----
// Assertions on the audio port outputs
`timescale 1ns/100ps
module apc_port_props (
  // Clock, reset and register port
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire apc_pkg::apc_reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  // Pins and codec state
  input wire logic primary_bit_clock_in,
  input wire logic primary_data_in,
  input wire logic data_pin_in,
  input wire logic general_purpose_pin_in,
  input wire logic codec_powered_down_in,
  // Routed outputs
  input wire logic primary_bit_clock_out,
  input wire logic primary_frame_clock_out,
  input wire logic primary_data_out,
  input wire logic secondary_bit_clock_out,
  input wire logic secondary_data_out
);
  ////////////////////////////////////////////////////////////////
  // Shadow registers and settle counter
  logic [7:0] sh [256];
  logic [2:0] age;
  wire up = age == 3'h7;
  wire [7:0] c2 = sh[8'h1D];
  wire [7:0] dv = sh[8'h1E];
  wire [7:0] ss = sh[8'h1F];
  wire [7:0] ins = sh[8'h20];
  wire [7:0] rt = sh[8'h21];
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      age <= 3'h0;
      for (int i = 0; i < 256; i++)
        sh[i] <= (i == 30) ? 8'h01 : 8'h00;
    end
    else
    begin
      if (!up)
        age <= age + 3'h1;
      if (reg_req_in.write)
        sh[reg_req_in.addr] <= reg_req_in.wdata;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_div_rd; reg_req_in.read && reg_req_in.addr == 8'h1E |=> reg_rdata_out == $past(dv);
  endproperty
  a_div_rd: assert property (p_div_rd) else $error("divider readback");
  property p_sdout; (up && !rt[0])[*4] |-> secondary_data_out == $past(primary_data_in, 3);
  endproperty
  a_sdout: assert property (p_sdout) else $error("secondary data out");
  property p_pdout;
    (up && rt[1] && ss[1:0] == 2'h0)[*4] |-> primary_data_out == $past(general_purpose_pin_in, 3);
  endproperty
  a_pdout: assert property (p_pdout) else $error("primary data out");
  property p_loop;
    (up && c2[5] && !rt[1] && !ins[0])[*4] |-> primary_data_out == $past(primary_data_in, 3);
  endproperty
  a_loop: assert property (p_loop) else $error("pin loopback");
  property p_sbclk;
    (up && !rt[6] && !sh[8'h1B][3])[*4] |-> secondary_bit_clock_out == $past(primary_bit_clock_in, 3);
  endproperty
  a_sbclk: assert property (p_sbclk) else $error("secondary bit clock");
  property p_pwclk; (up && rt[5:4] == 2'h2 && ss[4:2] == 3'h0)[*4]
    |-> primary_frame_clock_out == $past(general_purpose_pin_in, 3);
  endproperty
  a_pwclk: assert property (p_pwclk) else $error("primary frame clock");
  property p_pbdp;
    (up && rt[7] && ss[7:5] == 3'h3)[*4] |-> primary_bit_clock_out == $past(data_pin_in, 3);
  endproperty
  a_pbdp: assert property (p_pbdp) else $error("bit clock from data pin");
  property p_pwr; (up && !dv[7] && !rt[7])[*4] |-> !primary_bit_clock_out;
  endproperty
  a_pwr: assert property (p_pwr) else $error("divider off");
  property p_keep;
    (up && codec_powered_down_in && !c2[2] && !rt[7])[*4] |-> !primary_bit_clock_out;
  endproperty
  a_keep: assert property (p_keep) else $error("clocks while down");
endmodule : apc_port_props

bind apc_port apc_port_props u_props (.*);

// ---- tb/apc_host_model.sv ----
// Host model driving the serial pins
`timescale 1ns/100ps
module apc_host_model (
  // Clock
  input wire logic clock_in,
  // Free pattern control
  input wire logic free_in,
  input wire logic [2:0] pattern_in,
  // Serial pins
  output logic bclk_out = 1'b0,
  output logic wclk_out = 1'b0,
  output logic data_out = 1'b0
);
  logic busy = 1'b0;
  always @(posedge clock_in)
  begin
    if (free_in)
      {bclk_out, wclk_out, data_out} <= pattern_in;
    else if (!busy)
    begin
      bclk_out <= 1'b0;
      wclk_out <= 1'b0;
      data_out <= ~data_out;
    end
  end
  task automatic send(input logic [15:0] w);
    busy = 1'b1;
    for (int i = 0; i < 22; i++)
    begin
      @(posedge clock_in);
      bclk_out <= 1'b0;
      wclk_out <= (i >= 2 && i < 18);
      data_out <= (i >= 2 && i < 18) ? w[17 - i] : ~data_out;
      repeat (6) @(posedge clock_in);
      bclk_out <= 1'b1;
      repeat (5) @(posedge clock_in);
    end
    busy = 1'b0;
  endtask : send
endmodule : apc_host_model

// ---- tb/test_apc_port.sv ----
// Self-checking bench for the audio port block
`timescale 1ns/100ps
module test_apc_port;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  apc_pkg::apc_reg_req_t req = '0;
  logic [7:0] rdata, d;
  logic dpin = 1'b0, gp = 1'b0, down = 1'b0, free = 1'b0;
  logic [3:0] en = 4'h0;
  logic [1:0] fs = 2'h0;
  logic [2:0] pat = 3'h0;
  logic [31:0] rec = 32'h0, pso;
  logic pb, pw, pd, pbo, pwo, pdo, sbo, swo, sdo, pv;
  logic [15:0] seed = 16'h0009;
  logic [6:0] nv [4] = '{7'h02, 7'h05, 7'h00, 7'h7F};
  logic [7:0] rts [4] = '{8'h00, 8'h82, 8'hA0, 8'h00};
  logic [7:0] sss [4] = '{8'h00, 8'h00, 8'h60, 8'h00};
  logic [7:0] c2s [4] = '{8'h00, 8'h00, 8'h00, 8'h20};
  int err_count = 0;
  int check_count = 0;
  int n;

  always #4 clock_in = ~clock_in;

  apc_host_model host (.clock_in, .free_in(free), .pattern_in(pat),
    .bclk_out(pb), .wclk_out(pw), .data_out(pd));

  apc_port uut (.clock_in, .reset_n_in, .reg_req_in(req),
    .reg_rdata_out(rdata), .primary_bit_clock_in(pb), .primary_frame_clock_in(pw),
    .primary_data_in(pd), .data_pin_in(dpin), .general_purpose_pin_in(gp),
    .primary_bit_clock_out(pbo), .primary_bit_clock_oe_out(), .primary_frame_clock_out(pwo),
    .primary_frame_clock_oe_out(), .primary_data_out(pdo), .primary_data_oe_out(),
    .secondary_bit_clock_out(sbo), .secondary_frame_clock_out(swo), .secondary_data_out(sdo),
    .playback_processing_clock_en_in(en[0]), .playback_modulator_clock_en_in(en[1]),
    .record_processing_clock_en_in(en[2]), .record_modulator_clock_en_in(en[3]),
    .playback_sample_rate_clock_in(fs[0]), .record_sample_rate_clock_in(fs[1]),
    .codec_powered_down_in(down), .record_sample_in(rec), .playback_sample_out(pso),
    .playback_valid_out(pv));

  ////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      apc_pkg::OFF_CTRL_ONE: return apc_pkg::MASK_CTRL_ONE;
      apc_pkg::OFF_CTRL_TWO: return apc_pkg::MASK_CTRL_TWO;
      apc_pkg::OFF_IN_SEL: return apc_pkg::MASK_IN_SEL;
      default: return apc_pkg::MASK_FULL;
    endcase
  endfunction : wmask
  function automatic int ratio(input logic [6:0] v);
    return (v == 7'h00) ? 128 : int'(v);
  endfunction : ratio

  ////////////////////////////////////////////////////////////////
  // Bus, compare and report tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_in);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clock_in);
    req.write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_in);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_in);
    req.read <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
  task automatic rises(input int cyc, output int r);
    logic p;
    #1;
    r = 0;
    p = pbo;
    repeat (cyc)
    begin
      @(posedge clock_in);
      #1;
      r += int'(pbo === 1'b1 && p === 1'b0);
      p = pbo;
    end
  endtask : rises
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic frame(input logic [15:0] w, input logic [15:0] exp);
    int k = 0;
    fork
      host.send(w);
      while (pv !== 1'b1 && k < 400)
      begin
        @(posedge clock_in);
        #1;
        k++;
      end
    join
    if (k == 400)
    begin
      err_count++;
      test_done();
    end
    check(pso[31:16], exp);
    $display("test frame done");
  endtask : frame

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clock_in);
    reset_n_in <= 1'b1;
    for (int a = 8'h1B; a <= 8'h21; a++)
    begin
      rd(8'(a), d);
      check(d, (a == 30) ? apc_pkg::RST_DIV : apc_pkg::RST_ZERO);
      seed = lfsr(seed);
      wr(8'(a), seed[7:0]);
      rd(8'(a), d);
      check(d, seed[7:0] & wmask(8'(a)));
    end
    wr(8'h40, 8'h5A);
    rd(8'h40, d);
    check(d, 8'h00);
    $display("test registers done");
    wr(apc_pkg::OFF_OUT_ROUTE, 8'h00);
    wr(apc_pkg::OFF_IN_SEL, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wr(apc_pkg::OFF_CTRL_TWO, 8'(s));
      wr(apc_pkg::OFF_DIV, {1'b1, nv[s]});
      en <= 4'h1 << ((s + 1) % 4);
      rises(300, n);
      check(n, 0);
      en <= 4'h1 << s;
      rises(2 * ratio(nv[s]) + 10, n);
      rises(8 * ratio(nv[s]), n);
      check(n, 8);
    end
    wr(apc_pkg::OFF_DIV, 8'h02);
    rises(64, n);
    check(n, 0);
    down <= 1'b1;
    wr(apc_pkg::OFF_DIV, 8'h82);
    rises(64, n);
    check(n, 0);
    wr(apc_pkg::OFF_CTRL_TWO, 8'h07);
    rises(20, n);
    rises(16, n);
    check(n, 8);
    $display("test divider done");
    free <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(apc_pkg::OFF_SEC_SRC, sss[c]);
      wr(apc_pkg::OFF_OUT_ROUTE, rts[c]);
      wr(apc_pkg::OFF_CTRL_TWO, c2s[c]);
      repeat (40)
      begin
        @(posedge clock_in);
        seed = lfsr(seed);
        {pat, gp, dpin, fs, down} <= seed[7:0];
        en <= seed[11:8];
      end
      $display("test route %0d done", c);
    end
    free <= 1'b0;
    down <= 1'b0;
    wr(apc_pkg::OFF_CTRL_ONE, 8'hC0);
    wr(apc_pkg::OFF_CTRL_TWO, 8'h00);
    seed = lfsr(seed);
    frame(seed, seed);
    rec <= {lfsr(seed), 16'h0000};
    wr(apc_pkg::OFF_CTRL_TWO, 8'h10);
    frame(~seed, lfsr(seed));
    test_done();
  end
endmodule : test_apc_port
